// ---- common/ursb_pkg.sv ----
package ursb_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam logic [7:0] ADDR_STAT_A = 8'h00;
  localparam logic [7:0] ADDR_STAT_B = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  localparam int SA_PF   = 0;
  localparam int SA_FE   = 1;
  localparam int SA_OVR  = 2;
  localparam int SA_IDLE = 4;
  localparam int SA_FULL = 5;

  localparam int SB_RAF   = 0;
  localparam int SB_LONG_BREAK_DETECT_ENABLE = 1;
  localparam int SB_LONG_BREAK_TX_SELECT = 2;
  localparam int SB_WAKE_QUIET_FLAG_SELECT = 3;
  localparam int SB_RX_POLARITY_INVERT = 4;
  localparam int SB_EDGE  = 6;
  localparam int SB_LBK   = 7;

  localparam int C_NINE = 0;
  localparam int C_PE   = 1;
  localparam int C_ODD  = 2;
  localparam int C_STBY = 3;
  localparam int C_SBK  = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STB_RST  = 8'h00;

  // ****************************************
  // Character and timing figures
  // ****************************************
  localparam logic [3:0] DATA_BITS    = 4'h8;
  localparam logic [3:0] BRK_TX_SHORT = 4'hA;
  localparam logic [3:0] BRK_TX_LONG  = 4'hD;
  localparam logic [3:0] BRK_DET      = 4'hA;
  localparam logic [3:0] IDLE_BITS    = 4'hA;

  localparam int SYS_CLK_HZ  = 100_000_000;
  localparam int BIT_RATE_HZ = 115_200;
  localparam logic [15:0] BAUD_DIV_RST =
    16'(SYS_CLK_HZ / BIT_RATE_HZ);

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 9;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP
  } ursb_rx_t;

endpackage

// ---- tb/ursb_remote_node.sv ----
module ursb_remote_node #(
  parameter int BIT_CYC = 16
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Serial line driver and break meter
  // ****************************************
  int brk_cnt;
  int brk_len;

  initial begin
    rxd = 1'b1;
    brk_cnt = 0;
    brk_len = 0;
  end

  task automatic hold(input logic lvl, input int cyc);
    rxd <= lvl;
    repeat (cyc) @(posedge pclk);
  endtask

  // Long mark after each frame, so the idle line is always seen
  task automatic send(input logic [11:0] frm, input int nb,
                      input logic inv);
    @(posedge pclk);
    hold(inv, BIT_CYC);
    for (int i = 0; i < nb; i++) begin
      hold(frm[i] ^ inv, BIT_CYC);
    end
    hold(~inv, 12 * BIT_CYC);
  endtask

  task automatic send_low(input int cyc);
    @(posedge pclk);
    hold(1'b0, cyc);
    hold(1'b1, 12 * BIT_CYC);
  endtask

  always @(posedge pclk) begin
    if (txd === 1'b0) begin
      brk_cnt <= brk_cnt + 1;
    end else if (brk_cnt != 0) begin
      brk_len <= brk_cnt;
      brk_cnt <= 0;
    end
  end
endmodule

// ---- tb/ursb_top_assertions.sv ----
module ursb_top_assertions
  import ursb_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd
);
  // ****************************************
  // Shadow of what shapes a sent break
  // ****************************************
  logic        wr_take;
  logic        brk_cmd;
  logic [15:0] baud_ff;
  logic        nine_ff;
  logic        long_ff;
  logic [31:0] low_ff;
  logic [31:0] brk_cyc;

  assign wr_take = psel && penable && pready && pwrite;
  assign brk_cmd = wr_take && paddr == ADDR_CTRL && pwdata[C_SBK];
  assign brk_cyc = 32'(baud_ff) *
    32'((long_ff ? BRK_TX_LONG : BRK_TX_SHORT) + 4'(nine_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_ff <= BAUD_DIV_RST;
      nine_ff <= 1'b0;
      long_ff <= 1'b0;
    end else if (wr_take) begin
      if (paddr == ADDR_BAUD) baud_ff <= pwdata[15:0];
      if (paddr == ADDR_CTRL) nine_ff <= pwdata[C_NINE];
      if (paddr == ADDR_STAT_B) long_ff <= pwdata[SB_LONG_BREAK_TX_SELECT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_ff <= 32'h0;
    else if (!txd) low_ff <= low_ff + 32'h1;
    else low_ff <= 32'h0;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence

  a_ready_access: assert property (s_setup |=> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside a single access cycle");
  a_unmapped_err: assert property (s_setup ##0 (paddr > ADDR_BAUD)
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_bus_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read bus not quiet");
  a_stat_spare: assert property (s_read(ADDR_STAT_A)
    |-> prdata[31:6] == 26'h0 && !prdata[3]) else $error("spare bits set");
  a_ninth_zero: assert property (s_read(ADDR_DATA) ##0 !nine_ff
    |-> prdata[31:8] == 24'h0) else $error("ninth bit in 8-bit mode");
  a_sbk_reads0: assert property (s_read(ADDR_CTRL) |-> !prdata[C_SBK])
    else $error("break command reads back set");
  a_break_start: assert property ($fell(txd) |-> $past(brk_cmd))
    else $error("txd low without break command");
  a_break_len: assert property ($rose(txd) |-> low_ff == brk_cyc)
    else $error("break length wrong");
endmodule

bind ursb_top ursb_top_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd)
);

// ---- tb/ursb_top_test.sv ----
module ursb_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ursb_pkg::*;

  localparam int BT = 16;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic [31:0] rv;
  logic        er;
  int          failures;
  int          compares;
  int          n;

  ursb_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd)
  );

  ursb_remote_node #(.BIT_CYC(BT)) node (
    .pclk (pclk),
    .txd  (txd),
    .rxd  (rxd)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Ready is judged mid-cycle, settled, and holds to the next edge
    @(negedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 20) begin
      failures++;
    end
    rv = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    failures++;
    end_sim();
  end

  initial begin
    failures = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STAT_A, 32'h0);
    rd(ADDR_STAT_B, 32'h0);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_BAUD, 32'h364);
    xfer(8'h14, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(ADDR_BAUD, 32'(BT));
    fork
      node.send({4'h1, 8'hA5}, 9, 1'b0);
      begin
        repeat (80) @(posedge pclk);
        rd(ADDR_STAT_B, 32'h41);
      end
    join
    rd(ADDR_STAT_A, 32'h30);
    rd(ADDR_DATA, 32'hA5);
    rd(ADDR_STAT_A, 32'h0);
    rd(ADDR_STAT_B, 32'h40);
    wr(ADDR_STAT_B, 32'h44);
    node.send({4'h0, 8'h3C}, 9, 1'b0);
    rd(ADDR_STAT_A, 32'h32);
    rd(ADDR_DATA, 32'h3C);
    rd(ADDR_STAT_A, 32'h0);
    node.send({4'h0, 8'h3C}, 9, 1'b0);
    rd(ADDR_DATA, 32'h3C);
    rd(ADDR_STAT_A, 32'h12);
    xfer(ADDR_DATA, 1'b0, 32'h0);
    rd(ADDR_STAT_A, 32'h0);
    wr(ADDR_STAT_B, 32'h40);
    rd(ADDR_STAT_B, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    for (int p = 0; p < 2; p++) begin
      node.send({3'h1, p[0], 8'h01}, 10, 1'b0);
      rd(ADDR_STAT_A, p ? 32'h30 : 32'h31);
      rd(ADDR_DATA, 32'h1);
      rd(ADDR_STAT_A, 32'h0);
    end
    wr(ADDR_CTRL, 32'h1);
    node.send({3'h1, 9'h1C3}, 10, 1'b0);
    rd(ADDR_STAT_A, 32'h30);
    rd(ADDR_DATA, 32'h1C3);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_STAT_B, 32'(i[1]) << 2);
      wr(ADDR_CTRL, 32'h10 | 32'(i[0]));
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (txd !== 1'b1 && n < 400);
      repeat (2) @(posedge pclk);
      chk(32'(node.brk_len), 32'(((i[1] ? 13 : 10) + i[0]) * BT));
    end
    wr(ADDR_STAT_B, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    // Nine frames into an 8-deep buffer: the last one overruns
    for (int i = 0; i < 9; i++) begin
      node.send({4'h1, 8'(i)}, 9, 1'b0);
    end
    rd(ADDR_STAT_A, 32'h34);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_DATA, 32'(i));
    end
    rd(ADDR_STAT_A, 32'h0);
    wr(ADDR_STAT_B, 32'h42);
    node.send_low(10 * BT + 8);
    rd(ADDR_STAT_B, 32'h42);
    node.send_low(13 * BT);
    rd(ADDR_STAT_B, 32'hC2);
    xfer(ADDR_STAT_A, 1'b0, 32'h0);
    chk(rv & 32'h23, 32'h0);
    wr(ADDR_STAT_B, 32'hC2);
    rd(ADDR_STAT_B, 32'h2);
    wr(ADDR_STAT_B, 32'h0);
    xfer(ADDR_DATA, 1'b0, 32'h0);
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_STAT_B, 32'(w) << 3);
      wr(ADDR_CTRL, 32'h8);
      node.send({4'h1, 8'h77}, 9, 1'b0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_STAT_A, w ? 32'h10 : 32'h0);
      xfer(ADDR_DATA, 1'b0, 32'h0);
    end
    // Inverted line last: turning inversion off would fake a start bit
    wr(ADDR_STAT_B, 32'h10);
    node.hold(1'b0, 1);
    wr(ADDR_STAT_B, 32'h50);
    node.send({4'h1, 8'h5A}, 9, 1'b1);
    rd(ADDR_STAT_A, 32'h30);
    rd(ADDR_DATA, 32'h5A);
    rd(ADDR_STAT_B, 32'h50);
    end_sim();
  end
endmodule

// ---- verilog/ursb_fifo.sv ----
module ursb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      held;
  logic             push;
  logic             pop;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;

  assign in_ready  = (cnt_ff != (AW + 1)'(DEPTH));
  assign push      = in_valid & in_ready;
  assign pop       = out_valid_ff & out_ready;
  assign nxt_rd    = rd_ff + AW'(pop);
  // Entries left after this cycle's read, not counting its write
  assign held      = cnt_ff - (AW + 1)'(pop);
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= wr_ff + AW'(push);
      rd_ff  <= nxt_rd;
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // Head is read one cycle late, so a word written into an
  // empty buffer shows up on the cycle after next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      out_valid_ff <= (held != '0);
      out_data_ff  <= mem_ff[nxt_rd];
    end
  end

endmodule

// ---- verilog/ursb_top.sv ----
// How it works
// - stop bit sampled low sets framing error with the receive-full flag
// - framing error clears by status A read with it set, then data read
// - parity mismatch with parity enabled sets parity error with full flag
// - parity error clears by status A read followed by data read
// - break detected with break detect enabled sets sticky flag, write one
// - active receive edge sets sticky flag, polarity per inversion, write one
// - inversion control flips the receive line for every receive purpose
// - wake select decides if idle that ends standby sets the idle flag
// - transmitted break is 10 or 13 bit times, one more in nine-bit mode
// - transmit long-break select never touches framing error detection
// - break threshold is 10 or 11 bits, one more in nine-bit mode
// - long-break detect enabled blocks framing error and receive-full
// - active flag sets at valid start bit, clears on idle line
// - nine-bit mode gives a ninth data bit above the received byte
//
// The register addresses and the APB slave port were chosen for this implementation.
module ursb_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd
);
  import ursb_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        txd_ff;
  logic [7:0]  ctrl_ff;
  logic [7:0]  stb_ff;
  logic [15:0] baud_ff;
  logic        stby_ff;
  logic        fe_ff;
  logic        pf_ff;
  logic        ovr_ff;
  logic        idle_ff;
  logic [7:0]  arm_ff;
  logic [2:0]  sync_ff;
  logic        rx_lvl_ff;
  logic        line_q_ff;
  logic [15:0] run_tmr_ff;
  logic [3:0]  run_bits_ff;
  ursb_rx_t    rx_st_ff;
  logic [15:0] rx_tmr_ff;
  logic [3:0]  idx_ff;
  logic [8:0]  shift_ff;
  logic        par_ff;
  logic        perr_ff;
  logic        tx_act_ff;
  logic [15:0] tx_tmr_ff;
  logic [3:0]  tx_bits_ff;

  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        line;
  logic        edge_ev;
  logic        run_tick;
  logic        brk_ev;
  logic        idle_ev;
  logic        rx_tick;
  logic        nine;
  logic [3:0]  nbits;
  logic [3:0]  brk_thr;
  logic [3:0]  idle_thr;
  logic [3:0]  brk_len;
  logic        char_done;
  logic        stop_bad;
  logic        keep_char;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [8:0]  fifo_data;
  logic [8:0]  rx_word;
  logic        data_rd;
  logic        stat_a_rd;
  logic [7:0]  stat_a;
  logic [7:0]  stat_b;

  // ****************************************
  // Bus decode
  // ****************************************
  assign acc     = psel & penable & pready_ff;
  assign wr_acc  = acc & pwrite;
  assign rd_acc  = acc & ~pwrite;
  assign mapped  = (paddr == ADDR_STAT_A) || (paddr == ADDR_STAT_B) ||
                   (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_BAUD);
  assign data_rd   = rd_acc && (paddr == ADDR_DATA);
  assign stat_a_rd = rd_acc && (paddr == ADDR_STAT_A);
  assign nine      = ctrl_ff[C_NINE];

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign txd     = txd_ff;

  always_comb begin
    stat_a          = 8'h00;
    stat_a[SA_PF]   = pf_ff;
    stat_a[SA_FE]   = fe_ff;
    stat_a[SA_OVR]  = ovr_ff;
    stat_a[SA_IDLE] = idle_ff;
    stat_a[SA_FULL] = fifo_valid;
    stat_b          = stb_ff;
  end

  // Zero wait state: data captured in setup, pready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped;
      prdata_ff  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_STAT_A: prdata_ff[7:0]  <= stat_a;
          ADDR_STAT_B: prdata_ff[7:0]  <= stat_b;
          ADDR_DATA:   prdata_ff[8:0]  <= fifo_data;
          ADDR_CTRL:   prdata_ff[7:0]  <= {ctrl_ff[7:4], stby_ff,
                                           ctrl_ff[2:0]};
          ADDR_BAUD:   prdata_ff[15:0] <= baud_ff;
          default:     prdata_ff       <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      baud_ff <= BAUD_DIV_RST;
    end else if (wr_acc && paddr == ADDR_CTRL) begin
      ctrl_ff <= pwdata[7:0] & ~(8'h01 << C_SBK);
    end else if (wr_acc && paddr == ADDR_BAUD) begin
      baud_ff <= pwdata[15:0];
    end
  end

  // Standby ends by hardware when an idle line is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_ff <= 1'b0;
    end else if (wr_acc && paddr == ADDR_CTRL) begin
      stby_ff <= pwdata[C_STBY];
    end else if (idle_ev) begin
      stby_ff <= 1'b0;
    end
  end

  // Status B: sticky events, controls, live active flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_ff <= STB_RST;
    end else begin
      if (wr_acc && paddr == ADDR_STAT_B) begin
        stb_ff[SB_LONG_BREAK_DETECT_ENABLE] <= pwdata[SB_LONG_BREAK_DETECT_ENABLE];
        stb_ff[SB_LONG_BREAK_TX_SELECT] <= pwdata[SB_LONG_BREAK_TX_SELECT];
        stb_ff[SB_WAKE_QUIET_FLAG_SELECT] <= pwdata[SB_WAKE_QUIET_FLAG_SELECT];
        stb_ff[SB_RX_POLARITY_INVERT] <= pwdata[SB_RX_POLARITY_INVERT];
        if (pwdata[SB_LBK]) begin
          stb_ff[SB_LBK] <= 1'b0;
        end
        if (pwdata[SB_EDGE]) begin
          stb_ff[SB_EDGE] <= 1'b0;
        end
      end
      // Set beats a same-cycle write-one clear
      if (brk_ev && stb_ff[SB_LONG_BREAK_DETECT_ENABLE]) begin
        stb_ff[SB_LBK] <= 1'b1;
      end
      if (edge_ev) begin
        stb_ff[SB_EDGE] <= 1'b1;
      end
      if (rx_st_ff == RX_START && rx_tick && !line) begin
        stb_ff[SB_RAF] <= 1'b1;
      end else if (idle_ev) begin
        stb_ff[SB_RAF] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive line conditioning
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff   <= 3'h7;
      rx_lvl_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], rxd};
      if (sync_ff[1] == sync_ff[2]) begin
        rx_lvl_ff <= sync_ff[2];
      end
    end
  end

  assign line    = rx_lvl_ff ^ stb_ff[SB_RX_POLARITY_INVERT];
  assign edge_ev = line_q_ff & ~line;

  // Run length of the current line level in whole bit times
  assign run_tick = (run_tmr_ff >= baud_ff - 16'h0001);
  assign brk_thr  = BRK_DET + {3'h0, nine} +
                    {3'h0, stb_ff[SB_LONG_BREAK_DETECT_ENABLE]};
  assign idle_thr = IDLE_BITS + {3'h0, nine};
  assign brk_ev   = run_tick && !line &&
                    (run_bits_ff == brk_thr - 4'h1);
  assign idle_ev  = run_tick && line &&
                    (run_bits_ff == idle_thr - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q_ff   <= 1'b1;
      run_tmr_ff  <= 16'h0000;
      run_bits_ff <= 4'h0;
    end else begin
      line_q_ff <= line;
      if (line != line_q_ff) begin
        run_tmr_ff  <= 16'h0000;
        run_bits_ff <= 4'h0;
      end else if (run_tick) begin
        run_tmr_ff <= 16'h0000;
        // Saturates so each break or idle fires once
        if (run_bits_ff != 4'hF) begin
          run_bits_ff <= run_bits_ff + 4'h1;
        end
      end else begin
        run_tmr_ff <= run_tmr_ff + 16'h0001;
      end
    end
  end

  // ****************************************
  // Receive state machine
  // ****************************************
  assign rx_tick   = (rx_tmr_ff == 16'h0000);
  assign nbits     = DATA_BITS + {3'h0, nine};
  assign char_done = (rx_st_ff == RX_STOP) && rx_tick;
  assign stop_bad  = ~line;
  // Characters heard in standby are dropped, not buffered
  assign keep_char = char_done && !stb_ff[SB_LONG_BREAK_DETECT_ENABLE] && !stby_ff;
  assign rx_word   = nine ? shift_ff : {1'b0, shift_ff[8:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff  <= RX_IDLE;
      rx_tmr_ff <= 16'h0000;
      idx_ff    <= 4'h0;
      shift_ff  <= 9'h000;
      par_ff    <= 1'b0;
      perr_ff   <= 1'b0;
    end else begin
      if (!rx_tick) begin
        rx_tmr_ff <= rx_tmr_ff - 16'h0001;
      end
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (edge_ev) begin
            rx_st_ff  <= RX_START;
            rx_tmr_ff <= {1'b0, baud_ff[15:1]};
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_st_ff  <= line ? RX_IDLE : RX_DATA;
            rx_tmr_ff <= baud_ff - 16'h0001;
            idx_ff    <= 4'h0;
            par_ff    <= 1'b0;
            perr_ff   <= 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            shift_ff  <= {line, shift_ff[8:1]};
            par_ff    <= par_ff ^ line;
            idx_ff    <= idx_ff + 4'h1;
            rx_tmr_ff <= baud_ff - 16'h0001;
            if (idx_ff == nbits - 4'h1) begin
              rx_st_ff <= ctrl_ff[C_PE] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_tick) begin
            perr_ff   <= par_ff ^ line ^ ctrl_ff[C_ODD];
            rx_tmr_ff <= baud_ff - 16'h0001;
            rx_st_ff  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_st_ff <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  ursb_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (keep_char),
    .in_ready  (fifo_ready),
    .in_data   (rx_word),
    .out_valid (fifo_valid),
    .out_ready (data_rd),
    .out_data  (fifo_data)
  );

  // ****************************************
  // Read-sequence cleared flags
  // ****************************************
  // Status A read arms the bits it showed; data read clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 8'h00;
    end else if (stat_a_rd) begin
      arm_ff <= prdata_ff[7:0];
    end else if (data_rd) begin
      arm_ff <= 8'h00;
    end
  end

  // Long-break select is not read here: framing is unaffected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_ff   <= 1'b0;
      pf_ff   <= 1'b0;
      ovr_ff  <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      if (data_rd && arm_ff[SA_FE]) begin
        fe_ff <= 1'b0;
      end
      if (data_rd && arm_ff[SA_PF]) begin
        pf_ff <= 1'b0;
      end
      if (data_rd && arm_ff[SA_OVR]) begin
        ovr_ff <= 1'b0;
      end
      if (data_rd && arm_ff[SA_IDLE]) begin
        idle_ff <= 1'b0;
      end
      if (keep_char && fifo_ready && stop_bad) begin
        fe_ff <= 1'b1;
      end
      if (keep_char && fifo_ready && perr_ff) begin
        pf_ff <= 1'b1;
      end
      if (keep_char && !fifo_ready) begin
        ovr_ff <= 1'b1;
      end
      if (idle_ev && (!stby_ff || stb_ff[SB_WAKE_QUIET_FLAG_SELECT])) begin
        idle_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Break transmitter
  // ****************************************
  // Format bit of the command write itself sizes the break
  assign brk_len = (stb_ff[SB_LONG_BREAK_TX_SELECT] ? BRK_TX_LONG : BRK_TX_SHORT) +
                   {3'h0, pwdata[C_NINE]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_act_ff  <= 1'b0;
      tx_tmr_ff  <= 16'h0000;
      tx_bits_ff <= 4'h0;
      txd_ff     <= 1'b1;
    end else if (!tx_act_ff) begin
      txd_ff <= 1'b1;
      if (wr_acc && paddr == ADDR_CTRL && pwdata[C_SBK]) begin
        tx_act_ff  <= 1'b1;
        tx_tmr_ff  <= baud_ff - 16'h0001;
        tx_bits_ff <= brk_len - 4'h1;
        txd_ff     <= 1'b0;
      end
    end else if (tx_tmr_ff != 16'h0000) begin
      tx_tmr_ff <= tx_tmr_ff - 16'h0001;
    end else if (tx_bits_ff != 4'h0) begin
      tx_tmr_ff  <= baud_ff - 16'h0001;
      tx_bits_ff <= tx_bits_ff - 4'h1;
    end else begin
      tx_act_ff <= 1'b0;
      txd_ff    <= 1'b1;
    end
  end

endmodule
